// [design/blade_clean_sequencer.sv]
`timescale 1ns/1ps
// How it works
// (RULE_01) Blade stays off the drum while copying or idle; only cleaning engages it.
// (RULE_02) Engage the blade after process control or at trigger-chosen times.
// (RULE_03) Watch the release-arm switch; flag a blade position fault if it disagrees.
// (RULE_04) Two setting sets, normal and low humidity, picked by humidity threshold.
// (RULE_05) Threshold select: 0 no switching, 1/2/3 pick 0.0022/0.0040/0.0060.
// (RULE_06) Trigger mode: 0 never, 1 after process control, 2 after interval.
// (RULE_07) Mode 1 cleans only after cold-start or idle process control, enabled.
// (RULE_08) Mode 2 interval expiring during a job waits for the job to end.
// (RULE_09) Interval in minutes 5..1440; clean once elapsed time exceeds it.
// (RULE_10) Contact time 10..90 s; then retract until the next cleaning.
// (RULE_11) Manual command cleans whatever the trigger mode, even when off.
// (RULE_12) Engage, drum forward for contact time, reverse 0.2 s, stop, release.
// (RULE_13) 0.1 s release pulse after power-on, door close and each job start.
// (RULE_14) Check the switch after each action; on fault abort and release. Code checks only after the engage and release pulses.
module blade_clean_sequencer #(
  parameter int TICK_CYCLES = blade_clean_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [1:0]  humidity_threshold_select,
  input  wire logic [15:0] abs_humidity,
  input  wire logic [1:0]  trigger_mode_normal,
  input  wire logic [1:0]  trigger_mode_low,
  input  wire logic [10:0] clean_interval_normal,
  input  wire logic [10:0] clean_interval_low,
  input  wire logic [6:0]  contact_time_normal,
  input  wire logic [6:0]  contact_time_low,
  input  wire logic        auto_process_enable,
  input  wire logic        idle_process_enable,
  input  wire logic        process_done,
  input  wire logic        process_cold_start,
  input  wire logic        process_idle_start,
  input  wire logic        job_active,
  input  wire logic        manual_clean_command,
  input  wire logic        fault_clear,
  input  wire logic        front_door_closed,
  input  wire logic        blade_switch_pressed,
  output logic             sol_engage,
  output logic             sol_release,
  output logic             drum_forward,
  output logic             drum_reverse,
  output logic             blade_position_fault,
  output logic             cleaning_busy,
  output logic             low_humidity_mode
);

  phase_timer_if tif ();

  phase_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tif     (tif)
  );

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: accepted once second and third stages agree
  logic [2:0] door_sync;
  logic [2:0] sw_sync;
  logic       door_level;
  logic       door_prev;
  logic       sw_level;
  logic       job_prev;

  // Door taken as closed at reset, else the pin's idle level fakes a close
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      door_sync  <= 3'h7;
      sw_sync    <= 3'h0;
      door_level <= 1'b1;
      sw_level   <= 1'b0;
    end else begin
      door_sync <= {door_sync[1:0], front_door_closed};
      sw_sync   <= {sw_sync[1:0], blade_switch_pressed};
      if (door_sync[2] == door_sync[1]) begin
        door_level <= door_sync[2];
      end
      if (sw_sync[2] == sw_sync[1]) begin
        sw_level <= sw_sync[2];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      door_prev <= 1'b1;
      job_prev  <= 1'b0;
    end else begin
      door_prev <= door_level;
      job_prev  <= job_active;
    end
  end

  logic door_close_evt;
  logic job_start_evt;
  assign door_close_evt = door_level & ~door_prev;
  assign job_start_evt  = job_active & ~job_prev;

  //////////////////////////////////////////////////////////////////////////
  // Humidity mode and active setting set
  logic [15:0] hum_thr;
  always_comb begin
    case (humidity_threshold_select)
      blade_clean_pkg::HUM_SEL_1: hum_thr = blade_clean_pkg::HUM_THR_1;
      blade_clean_pkg::HUM_SEL_2: hum_thr = blade_clean_pkg::HUM_THR_2;
      default:                    hum_thr = blade_clean_pkg::HUM_THR_3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      low_humidity_mode <= 1'b0;
    end else begin
      low_humidity_mode <= (humidity_threshold_select !=    // see RULE_05
                            blade_clean_pkg::HUM_SEL_NONE) &&
                           (abs_humidity < hum_thr);        // see RULE_04
    end
  end

  logic [1:0]  act_trigger;
  logic [26:0] act_interval_ms;
  logic [16:0] act_contact_ms;
  assign act_trigger = low_humidity_mode ? trigger_mode_low
                                         : trigger_mode_normal;
  assign act_interval_ms = low_humidity_mode ?
      blade_clean_pkg::minutes_to_ms(clean_interval_low) :
      blade_clean_pkg::minutes_to_ms(clean_interval_normal); // see RULE_09
  assign act_contact_ms = low_humidity_mode ?
      blade_clean_pkg::seconds_to_ms(contact_time_low) :
      blade_clean_pkg::seconds_to_ms(contact_time_normal);   // see RULE_10

  //////////////////////////////////////////////////////////////////////////
  // Triggers and pending requests
  blade_clean_pkg::state_t state;
  blade_clean_pkg::state_t next_state;
  logic        start_now;
  logic [16:0] load_now;
  logic        fault_set;
  logic        take_release;
  logic        take_clean;
  logic        release_pending;
  logic        clean_pending;
  logic [26:0] elapsed_ms;
  logic [16:0] contact_ms;
  logic        interval_hit;
  logic        process_hit;
  logic        clean_set;

  assign interval_hit = (act_trigger == blade_clean_pkg::TRIG_INTERVAL) &&
                        (elapsed_ms > act_interval_ms) && !take_clean;
  assign process_hit = (act_trigger == blade_clean_pkg::TRIG_PROCESS) &&
                       process_done && auto_process_enable &&
                       (process_cold_start ||
                        (idle_process_enable && process_idle_start));
  assign clean_set = manual_clean_command ||                // see RULE_11
                     process_hit ||                         // see RULE_07
                     interval_hit;                          // see RULE_06

  // Elapsed time restarts with each cleaning; saturates rather than wraps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      elapsed_ms <= '0;
    end else if (take_clean) begin
      elapsed_ms <= '0;
    end else if (tif.tick && elapsed_ms != blade_clean_pkg::ELAPSED_MAX) begin
      elapsed_ms <= elapsed_ms + 27'h0000001;
    end
  end

  // New event wins over the take in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      release_pending <= 1'b1;                               // see RULE_13
      clean_pending   <= 1'b0;
    end else begin
      release_pending <= door_close_evt || job_start_evt ||  // see RULE_13
                         (release_pending && !take_release);
      clean_pending   <= clean_set ||                        // see RULE_02
                         (clean_pending && !take_clean);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    next_state   = state;
    start_now    = 1'b0;
    load_now     = blade_clean_pkg::RELEASE_PULSE_MS;
    fault_set    = 1'b0;
    take_release = 1'b0;
    take_clean   = 1'b0;
    case (state)
      blade_clean_pkg::S_IDLE: begin
        if (release_pending) begin
          next_state   = blade_clean_pkg::S_RELEASE;
          start_now    = 1'b1;
          take_release = 1'b1;
        end else if (clean_pending && !job_active &&        // see RULE_08
                     !blade_position_fault) begin
          next_state = blade_clean_pkg::S_ENGAGE;           // see RULE_01
          start_now  = 1'b1;
          load_now   = blade_clean_pkg::ENGAGE_PULSE_MS;
          take_clean = 1'b1;
        end
      end
      blade_clean_pkg::S_ENGAGE: begin
        if (tif.done) begin
          start_now = 1'b1;
          if (sw_level) begin
            next_state = blade_clean_pkg::S_FWD;            // see RULE_12
            load_now   = contact_ms;
          end else begin
            next_state = blade_clean_pkg::S_RELEASE;        // see RULE_14
            fault_set  = 1'b1;                              // see RULE_03
          end
        end
      end
      blade_clean_pkg::S_FWD: begin
        if (tif.done) begin
          next_state = blade_clean_pkg::S_REV;              // see RULE_12
          start_now  = 1'b1;
          load_now   = blade_clean_pkg::REVERSE_MS;
        end
      end
      blade_clean_pkg::S_REV: begin
        if (tif.done) begin
          next_state = blade_clean_pkg::S_RELEASE;          // see RULE_12
          start_now  = 1'b1;
        end
      end
      blade_clean_pkg::S_RELEASE: begin
        if (tif.done) begin
          next_state = blade_clean_pkg::S_IDLE;
          fault_set  = sw_level;                            // see RULE_14
        end
      end
      default: begin
        next_state = blade_clean_pkg::S_IDLE;
      end
    endcase
  end

  // Outputs follow the state they belong to, in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state         <= blade_clean_pkg::S_IDLE;
      sol_engage    <= 1'b0;
      sol_release   <= 1'b0;
      drum_forward  <= 1'b0;
      drum_reverse  <= 1'b0;
      cleaning_busy <= 1'b0;
    end else begin
      state         <= next_state;
      sol_engage    <= next_state == blade_clean_pkg::S_ENGAGE;
      sol_release   <= next_state == blade_clean_pkg::S_RELEASE;
      drum_forward  <= next_state == blade_clean_pkg::S_FWD;
      drum_reverse  <= next_state == blade_clean_pkg::S_REV;
      cleaning_busy <= (next_state == blade_clean_pkg::S_ENGAGE) ||
                       (next_state == blade_clean_pkg::S_FWD) ||
                       (next_state == blade_clean_pkg::S_REV);
    end
  end

  // Settings may change mid-cycle; contact time is frozen at engage
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tif.start  <= 1'b0;
      tif.load_ms <= blade_clean_pkg::RELEASE_PULSE_MS;
      contact_ms <= blade_clean_pkg::MS_PER_S;
    end else begin
      tif.start   <= start_now;
      tif.load_ms <= load_now;
      if (take_clean) begin
        contact_ms <= act_contact_ms;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blade_position_fault <= 1'b0;
    end else begin
      blade_position_fault <= fault_set ||                  // see RULE_03
                              (blade_position_fault && !fault_clear);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  logic [16:0] fwd_ticks;
  always_ff @(posedge clk) begin
    if (sys_rst || state == blade_clean_pkg::S_ENGAGE) begin
      fwd_ticks <= '0;
    end else if (drum_forward && tif.tick && !tif.start && !tif.done) begin
      fwd_ticks <= fwd_ticks + 17'h00001;
    end
  end

  property p_off_drum_when_idle;
    @(posedge clk) disable iff (sys_rst)
      !cleaning_busy |-> !sol_engage && !drum_forward && !drum_reverse;
  endproperty
  a_off_drum_when_idle: assert property (p_off_drum_when_idle) // see RULE_01
    else $error("Blade or drum active outside a cleaning cycle");

  property p_contact_length;
    @(posedge clk) disable iff (sys_rst)
      $fell(drum_forward) |-> fwd_ticks == contact_ms && drum_reverse;
  endproperty
  a_contact_length: assert property (p_contact_length) // see RULE_10
    else $error("Forward run length differs from contact time");

  property p_reverse_then_release;
    @(posedge clk) disable iff (sys_rst)
      $fell(drum_reverse) |-> sol_release && !drum_forward;
  endproperty
  a_reverse_then_release: assert property (p_reverse_then_release) // see RULE_12
    else $error("Reverse not followed by release");

  property p_no_engage_in_job;
    @(posedge clk) disable iff (sys_rst)
      $rose(sol_engage) |-> $past(job_active) == 1'b0;
  endproperty
  a_no_engage_in_job: assert property (p_no_engage_in_job) // see RULE_08
    else $error("Cleaning started during a job");

  property p_missing_switch_aborts;
    @(posedge clk) disable iff (sys_rst)
      state == blade_clean_pkg::S_ENGAGE && tif.done && !sw_level
      |=> blade_position_fault && sol_release && !drum_forward;
  endproperty
  a_missing_switch_aborts: assert property (p_missing_switch_aborts) // see RULE_14
    else $error("Switch fault did not abort to release");

  property p_no_switching_sel0;
    @(posedge clk) disable iff (sys_rst)
      humidity_threshold_select == blade_clean_pkg::HUM_SEL_NONE
      |=> !low_humidity_mode;
  endproperty
  a_no_switching_sel0: assert property (p_no_switching_sel0) // see RULE_05
    else $error("Low humidity mode with switching disabled");

  property p_manual_accepted;
    @(posedge clk) disable iff (sys_rst)
      manual_clean_command |=> clean_pending || sol_engage;
  endproperty
  a_manual_accepted: assert property (p_manual_accepted) // see RULE_11
    else $error("Manual cleaning command lost");

  property p_job_start_release;
    @(posedge clk) disable iff (sys_rst)
      job_start_evt |=> release_pending || sol_release;
  endproperty
  a_job_start_release: assert property (p_job_start_release) // see RULE_13
    else $error("Job start did not request a release pulse");

  property p_process_off_no_clean;
    @(posedge clk) disable iff (sys_rst)
      !clean_pending && !manual_clean_command && !interval_hit &&
      !process_hit |=> !clean_pending;
  endproperty
  a_process_off_no_clean: assert property (p_process_off_no_clean) // see RULE_07
    else $error("Cleaning requested without a trigger");

endmodule

// [design/blade_clean_pkg.sv]
package blade_clean_pkg;

  // Time base
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  localparam int MS_W      = 17;
  localparam int ELAPSED_W = 27;
  localparam int HUM_W     = 16;
  localparam int MIN_W     = 11;
  localparam int SEC_W     = 7;

  // Phase lengths in 1 ms ticks
  localparam logic [MS_W-1:0] RELEASE_PULSE_MS = 17'h00064;
  localparam logic [MS_W-1:0] ENGAGE_PULSE_MS  = 17'h00064;
  localparam logic [MS_W-1:0] REVERSE_MS       = 17'h000C8;
  localparam logic [MS_W-1:0] MS_PER_S         = 17'h003E8;
  localparam logic [ELAPSED_W-1:0] MS_PER_MIN  = 27'h000EA60;
  localparam logic [ELAPSED_W-1:0] ELAPSED_MAX = 27'h7FFFFFF;

  // Absolute humidity in units of 0.0001
  localparam logic [1:0] HUM_SEL_NONE = 2'h0;
  localparam logic [1:0] HUM_SEL_1    = 2'h1;
  localparam logic [1:0] HUM_SEL_2    = 2'h2;
  localparam logic [HUM_W-1:0] HUM_THR_1 = 16'h0016;
  localparam logic [HUM_W-1:0] HUM_THR_2 = 16'h0028;
  localparam logic [HUM_W-1:0] HUM_THR_3 = 16'h003C;

  localparam logic [1:0] TRIG_OFF      = 2'h0;
  localparam logic [1:0] TRIG_PROCESS  = 2'h1;
  localparam logic [1:0] TRIG_INTERVAL = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE    = 5'h01,
    S_ENGAGE  = 5'h02,
    S_FWD     = 5'h04,
    S_REV     = 5'h08,
    S_RELEASE = 5'h10
  } state_t;

  function automatic logic [MS_W-1:0] seconds_to_ms(
      input logic [SEC_W-1:0] s);
    seconds_to_ms = MS_W'(MS_W'(s) * MS_PER_S);
  endfunction

  function automatic logic [ELAPSED_W-1:0] minutes_to_ms(
      input logic [MIN_W-1:0] m);
    minutes_to_ms = ELAPSED_W'(ELAPSED_W'(m) * MS_PER_MIN);
  endfunction

endpackage

// [design/phase_timer_if.sv]
`timescale 1ns/1ps
interface phase_timer_if;
  logic                              start;
  logic [blade_clean_pkg::MS_W-1:0]  load_ms;
  logic                              done;
  logic                              tick;
  modport ctrl  (output start, output load_ms, input done, input tick);
  modport timer (input start, input load_ms, output done, output tick);
endinterface

// [design/phase_timer.sv]
`timescale 1ns/1ps
module phase_timer #(
  parameter int TICK_CYCLES = blade_clean_pkg::TICK_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  sys_rst,
  phase_timer_if.timer tif
);

  logic [31:0]                      pre;
  logic [blade_clean_pkg::MS_W-1:0] remaining;
  logic                             active;

  // Millisecond tick shared with the elapsed-time counter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pre      <= 32'h00000000;
      tif.tick <= 1'b0;
    end else if (pre == 32'(TICK_CYCLES - 1)) begin
      pre      <= 32'h00000000;
      tif.tick <= 1'b1;
    end else begin
      pre      <= pre + 32'h00000001;
      tif.tick <= 1'b0;
    end
  end

  // Start wins over a tick in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      remaining <= '0;
      active    <= 1'b0;
      tif.done  <= 1'b0;
    end else begin
      tif.done <= 1'b0;
      if (tif.start) begin
        remaining <= tif.load_ms;
        active    <= 1'b1;
      end else if (active && tif.tick) begin
        if (remaining <= 17'h00001) begin
          active   <= 1'b0;
          tif.done <= 1'b1;
        end else begin
          remaining <= remaining - 17'h00001;
        end
      end
    end
  end

  property p_done_ends_run;
    @(posedge clk) disable iff (sys_rst)
      tif.done |-> !active && $past(active);
  endproperty
  a_done_ends_run: assert property (p_done_ends_run) // see RULE_12
    else $error("Timer done without a running phase");

endmodule

// [tb/blade_mech_model.sv]
`timescale 1ns/1ps
module blade_mech_model (
  input  wire logic clk,
  input  wire logic sol_engage,
  input  wire logic sol_release,
  input  wire logic stuck_released,
  output logic      blade_switch_pressed
);
  logic engaged = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Latching arm: stays where the last pulse put it
  always @(posedge clk) begin
    if (sol_release) begin
      engaged <= 1'b0;
    end else if (sol_engage) begin
      engaged <= 1'b1;
    end
  end

  // Jammed arm never reaches the switch
  assign blade_switch_pressed = engaged & ~stuck_released;
endmodule

// [tb/second_blade_clean_sequencer_tb.sv]
`timescale 1ns/1ps
module second_blade_clean_sequencer_tb;
  localparam int TICKS = 1;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [1:0]  hum_sel = 2'h1;
  logic [15:0] abs_humidity = 16'h0064;
  logic [1:0]  trig_normal = 2'h0;
  logic [1:0]  trig_low = 2'h0;
  logic [10:0] interval_normal = 11'h05A;
  logic [6:0]  contact_normal = 7'h0C;
  logic [6:0]  contact_low = 7'h0A;
  logic        auto_en = 1'b0;
  logic        idle_en = 1'b0;
  logic        process_done = 1'b0;
  logic        cold = 1'b0;
  logic        idle = 1'b0;
  logic        job_active = 1'b0;
  logic        manual = 1'b0;
  logic        fault_clear = 1'b0;
  logic        door_closed = 1'b1;
  logic        stuck = 1'b0;
  logic        switch_pressed;
  logic        sol_engage;
  logic        sol_release;
  logic        drum_forward;
  logic        drum_reverse;
  logic        fault;
  logic        busy;
  logic        low_mode;
  logic [3:0]  code;
  logic [3:0]  seg_code [8];
  int          seg_len [8];
  int          seg_n;
  int          mismatches = 0;
  int          compares = 0;
  logic [15:0] thr [4] = '{16'h0016, 16'h0016, 16'h0028, 16'h003C};

  always #5 clk = ~clk;
  assign code = {sol_engage, drum_forward, drum_reverse, sol_release};

  blade_clean_sequencer #(.TICK_CYCLES(TICKS)) blade_clean_sequencer_i (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .humidity_threshold_select (hum_sel),
    .abs_humidity              (abs_humidity),
    .trigger_mode_normal       (trig_normal),
    .trigger_mode_low          (trig_low),
    .clean_interval_normal     (interval_normal),
    .clean_interval_low        (11'h00F),
    .contact_time_normal       (contact_normal),
    .contact_time_low          (contact_low),
    .auto_process_enable       (auto_en),
    .idle_process_enable       (idle_en),
    .process_done              (process_done),
    .process_cold_start        (cold),
    .process_idle_start        (idle),
    .job_active                (job_active),
    .manual_clean_command      (manual),
    .fault_clear               (fault_clear),
    .front_door_closed         (door_closed),
    .blade_switch_pressed      (switch_pressed),
    .sol_engage                (sol_engage),
    .sol_release               (sol_release),
    .drum_forward              (drum_forward),
    .drum_reverse              (drum_reverse),
    .blade_position_fault      (fault),
    .cleaning_busy             (busy),
    .low_humidity_mode         (low_mode)
  );

  blade_mech_model blade_mech_model_i (
    .clk                  (clk),
    .sol_engage           (sol_engage),
    .sol_release          (sol_release),
    .stuck_released       (stuck),
    .blade_switch_pressed (switch_pressed)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Phase of n ms lasts n ticks plus up to two cycles of start latency
  function automatic logic in_win(input int len, input int ms);
    return len >= ms * TICKS && len <= ms * TICKS + 2;
  endfunction

  // Splits one output burst into runs of equal output code
  task automatic record_burst();
    int         w;
    logic [3:0] c;
    seg_n = 0;
    w = 0;
    while (code === 4'h0 && w < 200) begin
      step(1);
      w++;
    end
    while (code !== 4'h0 && seg_n < 8 && w < 40000) begin
      c = code;
      seg_code[seg_n] = c;
      seg_len[seg_n] = 0;
      while (code === c && w < 40000) begin
        step(1);
        w++;
        seg_len[seg_n]++;
      end
      seg_n++;
    end
    check("burst bounded", 32'(w < 40000), 32'h1);
  endtask

  task automatic expect_release();
    record_burst();
    check("release runs", 32'(seg_n), 32'h1);
    check("release code", 32'(seg_code[0]), 32'h1);
    check("release len", 32'(in_win(seg_len[0], 100)), 32'h1);
  endtask

  task automatic expect_clean(input int fwd_s);
    record_burst();
    check("clean runs", 32'(seg_n), 32'h4);
    check("engage code", 32'(seg_code[0]), 32'h8);
    check("forward code", 32'(seg_code[1]), 32'h4);
    check("reverse code", 32'(seg_code[2]), 32'h2);
    check("release code", 32'(seg_code[3]), 32'h1);
    check("fwd len", 32'(in_win(seg_len[1], fwd_s * 1000)), 32'h1);
    check("rev len", 32'(in_win(seg_len[2], 200)), 32'h1);
    check("busy after", 32'(busy), 32'h0);
  endtask

  task automatic pulse_process(input logic a, input logic c, input logic i,
                               input logic ie);
    auto_en = a;
    cold = c;
    idle = i;
    idle_en = ie;
    process_done = 1'b1;
    step(1);
    process_done = 1'b0;
  endtask

  task automatic pulse_manual();
    manual = 1'b1;
    step(1);
    manual = 1'b0;
  endtask

  task automatic expect_quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      step(1);
      if (busy !== 1'b0 || sol_engage !== 1'b0) bad++;
    end
    check("stays retracted", 32'(bad), 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    step(6);
    check("outputs in reset", 32'({code, fault, busy}), 32'h0);
    sys_rst = 1'b0;
    expect_release();
    // Threshold table, one step below and at each level
    for (int s = 0; s < 4; s++) begin
      hum_sel = 2'(s);
      abs_humidity = thr[s] - 16'h0001;
      step(3);
      check("low below", 32'(low_mode), 32'(s != 0));
      abs_humidity = thr[s];
      step(3);
      check("low at thr", 32'(low_mode), 32'h0);
    end
    pulse_manual();
    expect_clean(12);
    trig_normal = 2'h1;
    pulse_process(1'b0, 1'b1, 1'b0, 1'b1);
    expect_quiet(30);
    pulse_process(1'b1, 1'b0, 1'b1, 1'b0);
    expect_quiet(30);
    pulse_process(1'b1, 1'b0, 1'b1, 1'b1);
    expect_clean(12);
    // Low humidity set: different contact time shows which set is in use
    abs_humidity = 16'h000A;
    trig_normal = 2'h0;
    trig_low = 2'h1;
    step(3);
    pulse_process(1'b1, 1'b1, 1'b0, 1'b0);
    expect_clean(10);
    abs_humidity = 16'h0064;
    job_active = 1'b1;
    expect_release();
    pulse_manual();
    expect_quiet(50);
    job_active = 1'b0;
    expect_clean(12);
    door_closed = 1'b0;
    step(5);
    door_closed = 1'b1;
    expect_release();
    // Interval mode, zero interval: due at once but held by the job
    job_active = 1'b1;
    expect_release();
    interval_normal = 11'h000;
    trig_normal = 2'h2;
    expect_quiet(50);
    job_active = 1'b0;
    step(1);
    // Mode off again once engaged, so the next interval does not fire
    trig_normal = 2'h0;
    expect_clean(12);
    // Arm jams: engage, then straight to release with fault
    stuck = 1'b1;
    pulse_manual();
    record_burst();
    check("fault runs", 32'(seg_n), 32'h2);
    check("fault engage", 32'(seg_code[0]), 32'h8);
    check("fault release", 32'(seg_code[1]), 32'h1);
    check("fault flag", 32'(fault), 32'h1);
    stuck = 1'b0;
    pulse_manual();
    expect_quiet(50);
    fault_clear = 1'b1;
    step(1);
    fault_clear = 1'b0;
    step(2);
    check("fault cleared", 32'(fault), 32'h0);
    conclude();
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule
